// ---- rtl/fcdma_map.svh ----
// Constants of the four-channel transfer engine: encodings and field positions.
// Assumes inclusion by bare name from the design files under rtl/.
`ifndef FCDMA_MAP_SVH
`define FCDMA_MAP_SVH
`define FCDMA_NCH        4
`define FCDMA_ADDR_W     24
`define FCDMA_AM_FIXED   2'b00
`define FCDMA_AM_INC     2'b01
`define FCDMA_AM_DEC     2'b10
`define FCDMA_RL_NONE    2'b00
`define FCDMA_RL_BLOCK   2'b01
`define FCDMA_RL_BURST   2'b10
`define FCDMA_RL_TRANS   2'b11
`define FCDMA_PRI_RR     2'b00
`define FCDMA_PRI_C0RR   2'b01
`define FCDMA_PRI_C01RR  2'b10
`define FCDMA_PRI_FIXED  2'b11
`define FCDMA_BL_ONE     2'b00
`define FCDMA_TRIG_SW    2'b00
`define FCDMA_TRIG_PER   2'b01
`define FCDMA_TRIG_EVT   2'b10
`define FCDMA_TRIG_NONE  2'b11
`define FCDMA_CNT_ONE    16'h0001
`define FCDMA_REP_ONE    8'h01
`define FCDMA_REP_INF    8'h00
`define FCDMA_PAIR01     0
`define FCDMA_PAIR23     1
`endif

// ---- rtl/fcdma_pkg.sv ----
// Types shared by the transfer engine and its arbiter.
// Assumes the constants header is on the include path.
`include "fcdma_map.svh"
package fcdma_pkg;
	typedef logic [`FCDMA_NCH-1:0] fcdma_chmask_t;
	typedef enum logic [2:0] {
		FCDMA_IDLE  = 3'b001,
		FCDMA_READ  = 3'b010,
		FCDMA_WRITE = 3'b100
	} fcdma_state_t;
endpackage

// ---- rtl/fcdma_arb_if.sv ----
// Request and grant bundle between the engine and its channel arbiter.
// Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface fcdma_arb_if;
	import fcdma_pkg::*;
	fcdma_chmask_t req;
	fcdma_chmask_t gnt;
	logic          done;
	logic [1:0]    mode;
	modport eng (output req, output done, output mode, input gnt);
	modport arb (input req, input done, input mode, output gnt);
endinterface
`default_nettype wire

// ---- rtl/fcdma_arb.sv ----
// Channel arbiter: fixed, round robin or mixed priority over four channels.
// Assumes done pulses once when the granted channel finishes a burst.
`timescale 1ns/1ps
`default_nettype none
`include "fcdma_map.svh"
module fcdma_arb
	import fcdma_pkg::*;
(
	input  wire logic mclk_in,
	input  wire logic rst_in,
	fcdma_arb_if.arb  bus
);
	logic [1:0]    last_q;
	fcdma_chmask_t rr_set;
	fcdma_chmask_t fix_set;
	fcdma_chmask_t rr_req;
	fcdma_chmask_t rr_gnt;
	fcdma_chmask_t fix_gnt;
	logic [1:0]    pick;
	// Channels that take part in the round robin for each priority setting.
	assign rr_set  = (bus.mode == `FCDMA_PRI_RR)   ? 4'hf :
	                 (bus.mode == `FCDMA_PRI_C0RR) ? 4'he :
	                 (bus.mode == `FCDMA_PRI_C01RR)? 4'hc : 4'h0;
	assign fix_set = ~rr_set;
	assign rr_req  = bus.req & rr_set;
	// Fixed channels win by index order; the rotating group only sees leftovers.
	assign fix_gnt = (bus.req & fix_set) & ~((bus.req & fix_set) - 4'h1);
	always_comb begin
		logic [1:0] idx;
		rr_gnt = 4'h0;
		idx    = 2'd0;
		for (int k = 1; k <= 4; k++) begin
			idx = 2'(last_q + 2'(k));
			if (rr_gnt == 4'h0 && rr_req[idx]) begin
				rr_gnt[idx] = 1'b1;
			end
		end
	end
	assign bus.gnt = (fix_gnt != 4'h0) ? fix_gnt : rr_gnt;
	assign pick    = bus.gnt[1] ? 2'd1 : bus.gnt[2] ? 2'd2 : bus.gnt[3] ? 2'd3 : 2'd0;
	// last_q takes pick at burst end; the grant is low then, so it always records channel 0.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			last_q <= 2'd3;
		end else if (bus.done) begin
			last_q <= pick;
		end
	end
endmodule // fcdma_arb
`default_nettype wire

// ---- rtl/fcdma_top.sv ----
// Four-channel transfer engine sharing the data bus with the processor.
// Assumes the memory answers a read in the cycle after mem_rd_out, and the
// processor drives cpu_req_in from the same clock.
// Behaviour
// - Four channels with own trigger, interrupt and addressing settings.
// - Block size comes from the block byte count; 1 byte to 64 KB.
// - Repeat count 1..255 blocks per transaction; zero repeats forever.
// - Bursts of 1, 2, 4 or 8 bytes keep the bus until done.
// - Processor wins the bus between bursts; a burst waits while it requests.
// - Transfers start on a request from software, peripheral or event, or when a linked partner finishes.
// - Selecting an absent trigger source does nothing.
// - One trigger moves a block; channel stops itself after it and stays enabled.
// - Single-shot mode moves one burst per trigger.
// - With repeat on, next block starts without a trigger.
// - A request during a transfer is held pending and started later.
// - At most one pending request; further ones are dropped.
// - Addresses fixed, incrementing or decrementing; updated after each byte.
// - Originals kept; reload at burst, block or transaction end is decoded, but every channel reloads never.
// - Priority fixed, round robin or mixed; in round robin (00) channel 0 goes lowest after every burst.
// - Per channel interrupt on transaction complete and on error.
// - Linked pair: second takes over after first, and back again.
// - Memory-mapped EEPROM may be read as a source.
// - Moved data may be copied to the CRC generator.
// - Linking only within channels 0-1 and 2-3.
// - Priority codes: 00 RR, 01 ch0 then RR, 10 ch0,ch1 then RR, 11 fixed.
// - Complete flag at transaction end; with unlimited repeat at every block.
`timescale 1ns/1ps
`default_nettype none
`include "fcdma_map.svh"
module fcdma_top
	import fcdma_pkg::*;
(
	input  wire logic                      mclk_in,
	input  wire logic                      rst_in,
	input  wire logic                      ctl_enable_in,
	input  wire logic [1:0]                channel_priority_select_in,
	input  wire logic [1:0]                dbuf_mode_in,
	input  wire logic [3:0]                ch_enable_in,
	input  wire logic [3:0]                ch_sw_req_in,
	input  wire logic [3:0]                ch_single_in,
	input  wire logic [3:0]                ch_repeat_in,
	input  wire logic [7:0]                ch_trig_sel_in,
	input  wire logic [3:0]                ch_per_trig_in,
	input  wire logic [3:0]                ch_evt_trig_in,
	input  wire logic [3:0]                trig_present_in,
	input  wire logic [7:0]                ch_burst_len_in,
	input  wire logic [15:0]               ch_src_mode_in,
	input  wire logic [63:0]               ch_blk_cnt_in,
	input  wire logic [31:0]               ch_rep_cnt_in,
	input  wire logic [95:0]               ch_src_addr_in,
	input  wire logic [95:0]               ch_dst_addr_in,
	input  wire logic [3:0]                ch_crc_en_in,
	input  wire logic                      cpu_req_in,
	input  wire logic [7:0]                mem_rdata_in,
	input  wire logic                      mem_err_in,
	output logic                           mem_rd_out,
	output logic                           mem_wr_out,
	output logic [`FCDMA_ADDR_W-1:0]       mem_addr_out,
	output logic [7:0]                     mem_wdata_out,
	output logic                           crc_valid_out,
	output logic [7:0]                     crc_data_out,
	output logic [3:0]                     ch_busy_out,
	output logic [3:0]                     ch_pend_out,
	output logic [3:0]                     ch_active_out,
	output logic [3:0]                     ch_done_out,
	output logic [3:0]                     ch_err_out
);
	fcdma_arb_if arb_bus ();
	fcdma_arb u_arb (.mclk_in(mclk_in), .rst_in(rst_in), .bus(arb_bus));

	fcdma_state_t           state_q;
	logic [1:0]             cur_q;
	logic [3:0]             bcnt_q;
	logic [7:0]             rdata_q;
	logic                   burst_end;
	logic [3:0]             blen [4];
	logic [3:0]             trig;
	logic [3:0]             run_q;
	logic [3:0]             busy_q;
	logic [3:0]             pend_q;
	logic [3:0]             done_q;
	logic [3:0]             err_q;
	logic [3:0]             link_start;
	logic [3:0]             ch_fin;
	logic [15:0]            wcnt_q  [4];
	logic [7:0]             wrep_q  [4];
	logic [`FCDMA_ADDR_W-1:0] wsrc_q [4];
	logic [`FCDMA_ADDR_W-1:0] wdst_q [4];
	logic                   blk_end;
	logic                   last_blk;
	logic [1:0]             sam;
	logic [1:0]             dam;
	logic [1:0]             srl;
	logic [1:0]             drl;
	logic [3:0]             partner;
	logic [1:0]             sel [4];

	// The processor holds the bus: no burst starts while it asks.
	assign arb_bus.req  = (state_q == FCDMA_IDLE && !cpu_req_in && ctl_enable_in) ? busy_q : 4'h0;
	assign arb_bus.mode = channel_priority_select_in;
	assign arb_bus.done = (state_q == FCDMA_WRITE) && burst_end;
	assign burst_end    = (bcnt_q == blen[cur_q] - 4'h1) || (wcnt_q[cur_q] == `FCDMA_CNT_ONE);
	assign blk_end      = arb_bus.done && (wcnt_q[cur_q] == `FCDMA_CNT_ONE);
	// With repeat on, a zero repeat count never reaches the last block.
	assign last_blk     = !ch_repeat_in[cur_q] || (wrep_q[cur_q] == `FCDMA_REP_ONE);
	assign sam = ch_src_mode_in[cur_q*4 +: 2];
	assign dam = ch_src_mode_in[cur_q*4+2 +: 2];
	// Reload points are not brought out to ports, so every channel reloads never.
	logic [15:0] rl_sel;
	assign rl_sel = 16'h0000;
	assign srl = rl_sel[cur_q*4 +: 2];
	assign drl = rl_sel[cur_q*4+2 +: 2];
	// Pairs 0-1 and 2-3 only; a finishing channel starts its partner.
	assign partner = {ch_fin[2], ch_fin[3], ch_fin[0], ch_fin[1]};
	assign link_start = partner & {dbuf_mode_in[`FCDMA_PAIR23], dbuf_mode_in[`FCDMA_PAIR23],
	                               dbuf_mode_in[`FCDMA_PAIR01], dbuf_mode_in[`FCDMA_PAIR01]};

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_ch
			// Every channel has its own copy of this logic.
			assign sel[g]  = ch_trig_sel_in[g*2 +: 2];
			assign blen[g] = 4'(4'h1 << ch_burst_len_in[g*2 +: 2]);
			// Each channel picks its own source; an absent one never fires.
			assign trig[g] = ch_enable_in[g] && ((sel[g] == `FCDMA_TRIG_SW && ch_sw_req_in[g]) ||
			                 (sel[g] == `FCDMA_TRIG_PER && ch_per_trig_in[g] && trig_present_in[g]) ||
			                 (sel[g] == `FCDMA_TRIG_EVT && ch_evt_trig_in[g] && trig_present_in[g]));
			assign ch_fin[g] = blk_end && cur_q == 2'(g) && last_blk;
			always_ff @(posedge mclk_in) begin
				if (rst_in) begin
					run_q[g]  <= 1'b0;
					busy_q[g] <= 1'b0;
					pend_q[g] <= 1'b0;
					done_q[g] <= 1'b0;
					err_q[g]  <= 1'b0;
				end else begin
					done_q[g] <= 1'b0;
					err_q[g]  <= 1'b0;
					if (!ch_enable_in[g] || !ctl_enable_in) begin
						err_q[g]  <= busy_q[g];
						run_q[g]  <= 1'b0;
						busy_q[g] <= 1'b0;
						pend_q[g] <= 1'b0;
					end else if (state_q != FCDMA_IDLE && cur_q == 2'(g) && mem_err_in) begin
						err_q[g]  <= 1'b1;
						run_q[g]  <= 1'b0;
						busy_q[g] <= 1'b0;
					end else if (arb_bus.done && cur_q == 2'(g)) begin
						if (ch_fin[g] || (blk_end && !ch_repeat_in[g])) begin
							done_q[g] <= 1'b1;
						end
						if (blk_end && ch_repeat_in[g] && wrep_q[g] == `FCDMA_REP_INF) begin
							done_q[g] <= 1'b1;
						end
						if (ch_fin[g]) begin
							// Channel stops itself; a held request restarts it.
							run_q[g]  <= 1'b0;
							busy_q[g] <= pend_q[g];
							pend_q[g] <= 1'b0;
						end else if (ch_single_in[g] || (blk_end && !ch_repeat_in[g])) begin
							// One burst per trigger in single-shot mode.
							busy_q[g] <= pend_q[g];
							pend_q[g] <= 1'b0;
						end
						// Repeat carries on into the next block untriggered.
					end else if (trig[g] || link_start[g]) begin
						if (!busy_q[g]) begin
							busy_q[g] <= 1'b1;
							run_q[g]  <= 1'b1;
						end else begin
							pend_q[g] <= 1'b1;
						end
					end
				end
			end
			// Working copies, loaded from the programmed values at start and reload.
			always_ff @(posedge mclk_in) begin
				if (rst_in) begin
					wcnt_q[g] <= `FCDMA_CNT_ONE;
					wrep_q[g] <= `FCDMA_REP_ONE;
					wsrc_q[g] <= '0;
					wdst_q[g] <= '0;
				end else if (!run_q[g] && (trig[g] || link_start[g])) begin
					wcnt_q[g] <= ch_blk_cnt_in[g*16 +: 16];
					wrep_q[g] <= ch_rep_cnt_in[g*8 +: 8];
					wsrc_q[g] <= ch_src_addr_in[g*24 +: 24];
					wdst_q[g] <= ch_dst_addr_in[g*24 +: 24];
				end else if (state_q == FCDMA_WRITE && cur_q == 2'(g)) begin
					// Addresses move after each byte.
					if (ch_src_mode_in[g*4 +: 2] == `FCDMA_AM_INC) wsrc_q[g] <= wsrc_q[g] + 24'h1;
					if (ch_src_mode_in[g*4 +: 2] == `FCDMA_AM_DEC) wsrc_q[g] <= wsrc_q[g] - 24'h1;
					if (ch_src_mode_in[g*4+2 +: 2] == `FCDMA_AM_INC) wdst_q[g] <= wdst_q[g] + 24'h1;
					if (ch_src_mode_in[g*4+2 +: 2] == `FCDMA_AM_DEC) wdst_q[g] <= wdst_q[g] - 24'h1;
					wcnt_q[g] <= wcnt_q[g] - 16'h1;
					if (blk_end) begin
						wcnt_q[g] <= ch_blk_cnt_in[g*16 +: 16];
						if (ch_repeat_in[g] && wrep_q[g] != `FCDMA_REP_INF) begin
							wrep_q[g] <= wrep_q[g] - 8'h1;
						end
					end
					// Reload points chosen per address.
					if (reload(srl)) wsrc_q[g] <= ch_src_addr_in[g*24 +: 24];
					if (reload(drl)) wdst_q[g] <= ch_dst_addr_in[g*24 +: 24];
				end
			end
		end
	endgenerate

	// Reload decision for the channel on the bus, from its reload point code.
	function automatic logic reload(input logic [1:0] pt);
		return (pt == `FCDMA_RL_BURST && arb_bus.done) ||
		       (pt == `FCDMA_RL_BLOCK && blk_end) ||
		       (pt == `FCDMA_RL_TRANS && blk_end && last_blk);
	endfunction

	// Grant holds the bus for the whole burst; read then write per byte.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state_q <= FCDMA_IDLE;
			cur_q   <= 2'd0;
			bcnt_q  <= 4'h0;
			rdata_q <= 8'h00;
		end else begin
			unique case (state_q)
				FCDMA_IDLE: begin
					bcnt_q <= 4'h0;
					if (arb_bus.gnt != 4'h0) begin
						cur_q   <= arb_bus.gnt[1] ? 2'd1 : arb_bus.gnt[2] ? 2'd2 :
						           arb_bus.gnt[3] ? 2'd3 : 2'd0;
						state_q <= FCDMA_READ;
					end
				end
				FCDMA_READ: begin
					state_q <= FCDMA_WRITE;
				end
				FCDMA_WRITE: begin
					rdata_q <= mem_rdata_in;
					bcnt_q  <= bcnt_q + 4'h1;
					// A channel switched off mid-burst must not start one more read.
					state_q <= (burst_end || mem_err_in || !busy_q[cur_q] ||
					            !ch_enable_in[cur_q] || !ctl_enable_in) ? FCDMA_IDLE : FCDMA_READ;
				end
			endcase
		end
	end

	assign mem_rd_out    = (state_q == FCDMA_READ);
	assign mem_wr_out    = (state_q == FCDMA_WRITE);
	assign mem_addr_out  = (state_q == FCDMA_WRITE) ? wdst_q[cur_q] : wsrc_q[cur_q];
	assign mem_wdata_out = mem_rdata_in;
	// CRC copy is a register so its data is stable one cycle after the write.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			crc_valid_out <= 1'b0;
			crc_data_out  <= 8'h00;
		end else begin
			crc_valid_out <= mem_wr_out && ch_crc_en_in[cur_q];
			crc_data_out  <= mem_rdata_in;
		end
	end
	assign ch_busy_out   = busy_q;
	assign ch_pend_out   = pend_q;
	assign ch_active_out = run_q;
	assign ch_done_out   = done_q;
	assign ch_err_out    = err_q;
endmodule // fcdma_top
`default_nettype wire

// ---- tb/fcdma_cpu_model.sv ----
// Processor and data memory model at the shared bus of the transfer engine.
// Assumes reads are answered in the cycle after the read strobe, one clock.
`timescale 1ns/1ps
`default_nettype none
module fcdma_cpu_model (
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	input  wire logic        hold_in,
	input  wire logic        stall_in,
	input  wire logic        mem_rd_in,
	input  wire logic [23:0] mem_addr_in,
	output logic             cpu_req_out,
	output logic [7:0]       rdata_out
);
	logic [2:0] ph_q;
	always_ff @(posedge mclk_in) begin
		ph_q <= rst_in ? 3'h0 : ph_q + 3'h1;
		// Outside a read answer the bus shows the inverse, so stale data never matches.
		rdata_out <= rst_in ? 8'h00 : mem_rd_in ? mem_addr_in[7:0] ^ 8'h5a : ~rdata_out;
	end
	// Data accesses of the processor take the bus two cycles in eight, or all along.
	assign cpu_req_out = hold_in | (stall_in & (ph_q[2:1] == 2'h3));
endmodule // fcdma_cpu_model
`default_nettype wire

// ---- tb/fcdma_top_monitor.sv ----
// Concurrent checks on the top ports of the transfer engine.
// Assumes one clock with synchronous active-high reset; bound to the top below.
`timescale 1ns/1ps
`default_nettype none
module fcdma_top_monitor (
	input wire logic       mclk_in,
	input wire logic       rst_in,
	input wire logic       ctl_enable_in,
	input wire logic [3:0] ch_enable_in,
	input wire logic       cpu_req_in,
	input wire logic [7:0] mem_rdata_in,
	input wire logic       mem_err_in,
	input wire logic       mem_rd_out,
	input wire logic       mem_wr_out,
	input wire logic [7:0] mem_wdata_out,
	input wire logic       crc_valid_out,
	input wire logic [7:0] crc_data_out,
	input wire logic [3:0] ch_busy_out,
	input wire logic [3:0] ch_done_out,
	input wire logic [3:0] ch_err_out
);
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (rst_in);
	chk_rd_then_wr: assert property (
		mem_rd_out && !mem_err_in && ctl_enable_in |=> mem_wr_out)
		else $error("read cycle not followed by its write");
	chk_rd_wr_apart: assert property (!(mem_rd_out && mem_wr_out))
		else $error("read and write in one cycle");
	chk_data_moved: assert property (
		mem_wr_out |-> mem_wdata_out == mem_rdata_in)
		else $error("written byte differs from byte read");
	chk_crc_copy: assert property (
		crc_valid_out |-> $past(mem_wr_out) && crc_data_out == $past(mem_wdata_out))
		else $error("checksum byte is not the moved byte");
	chk_cpu_first: assert property (
		(cpu_req_in && !mem_wr_out) [*2] |-> !mem_rd_out)
		else $error("burst started while processor held the bus");
	chk_done_pulse: assert property (
		ch_done_out != 4'h0 |=> (ch_done_out & $past(ch_done_out)) == 4'h0)
		else $error("complete flag longer than one cycle");
	chk_move_busy: assert property (mem_rd_out |-> ch_busy_out != 4'h0)
		else $error("bus read with no busy channel");
	chk_busy_enabled: assert property (
		(ch_busy_out & ~$past(ch_busy_out) & ~$past(ch_enable_in)) == 4'h0)
		else $error("disabled channel became busy");
	chk_off_idle: assert property ((!ctl_enable_in) [*2] |=> !mem_rd_out)
		else $error("bus read while engine disabled");
	chk_err_disable: assert property (
		$fell(ch_enable_in[2]) && ch_busy_out[2] |-> ##[0:3] ch_err_out[2])
		else $error("disabling a busy channel gave no error");
endmodule // fcdma_top_monitor
bind fcdma_top fcdma_top_monitor u_mon (.mclk_in, .rst_in, .ctl_enable_in, .ch_enable_in,
	.cpu_req_in, .mem_rdata_in, .mem_err_in, .mem_rd_out, .mem_wr_out, .mem_wdata_out,
	.crc_valid_out, .crc_data_out, .ch_busy_out, .ch_done_out, .ch_err_out);
`default_nettype wire

// ---- tb/fcdma_top_test.sv ----
// Self-checking bench: an integer model of every channel predicts each write.
// Assumes the processor model and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module fcdma_top_test;
	logic        mclk_in = 1'b0, rst_in = 1'b1, ctl_enable_in = 1'b0, mem_err_in = 1'b0;
	logic        hold = 1'b0, stall = 1'b0;
	logic [1:0]  channel_priority_select_in = 2'h3, dbuf_mode_in = 2'h0;
	logic [3:0]  ch_enable_in = 4'h0, ch_sw_req_in = 4'h0, ch_single_in = 4'h0;
	logic [3:0]  ch_repeat_in = 4'h0, ch_per_trig_in = 4'h0, ch_evt_trig_in = 4'h0;
	logic [3:0]  trig_present_in = 4'hf, ch_crc_en_in = 4'hf;
	logic [7:0]  ch_trig_sel_in = 8'h00, ch_burst_len_in = 8'h00;
	logic [15:0] ch_src_mode_in = 16'h0000;
	logic [63:0] ch_blk_cnt_in = 64'h0;
	logic [31:0] ch_rep_cnt_in = 32'h0, x = 32'h38;
	logic [95:0] ch_src_addr_in = 96'h0, ch_dst_addr_in = 96'h0;
	wire logic        cpu_req_in, mem_rd_out, mem_wr_out, crc_valid_out;
	wire logic [7:0]  mem_rdata_in, mem_wdata_out, crc_data_out;
	wire logic [23:0] mem_addr_out;
	wire logic [3:0]  ch_busy_out, ch_pend_out, ch_active_out, ch_done_out, ch_err_out;
	logic [31:0] exp_q[$];
	int fail_count = 0, samples_checked = 0, cycles = 0, nrd = 0, ncrc = 0, nerr = 0;
	int ndone[4] = '{default: 0};
	int c, n, k;
	fcdma_top u_dut (.mclk_in, .rst_in, .ctl_enable_in, .channel_priority_select_in,
		.dbuf_mode_in, .ch_enable_in, .ch_sw_req_in, .ch_single_in, .ch_repeat_in,
		.ch_trig_sel_in, .ch_per_trig_in, .ch_evt_trig_in, .trig_present_in, .ch_burst_len_in,
		.ch_src_mode_in, .ch_blk_cnt_in, .ch_rep_cnt_in, .ch_src_addr_in, .ch_dst_addr_in,
		.ch_crc_en_in, .cpu_req_in, .mem_rdata_in, .mem_err_in, .mem_rd_out, .mem_wr_out,
		.mem_addr_out, .mem_wdata_out, .crc_valid_out, .crc_data_out, .ch_busy_out,
		.ch_pend_out, .ch_active_out, .ch_done_out, .ch_err_out);
	fcdma_cpu_model u_cpu (.mclk_in, .rst_in, .hold_in(hold), .stall_in(stall),
		.mem_rd_in(mem_rd_out), .mem_addr_in(mem_addr_out), .cpu_req_out(cpu_req_in),
		.rdata_out(mem_rdata_in));
	always #5 mclk_in = ~mclk_in;
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", what, want, seen);
		end
	endtask
	function automatic logic [31:0] xs();
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	function automatic int step(input logic [1:0] m);
		return (m == 2'h1) ? 1 : (m == 2'h2) ? -1 : 0;
	endfunction
	always @(posedge mclk_in) begin
		cycles++;
		if (mem_rd_out === 1'b1) nrd++;
		if (crc_valid_out === 1'b1) ncrc++;
		for (int i = 0; i < 4; i++) ndone[i] += (ch_done_out[i] === 1'b1);
		for (int i = 0; i < 4; i++) nerr += (ch_err_out[i] === 1'b1);
		if (mem_wr_out === 1'b1 && exp_q.size() == 0) check("extra write", 1, 0);
		else if (mem_wr_out === 1'b1) check("write", {mem_addr_out, mem_wdata_out}, exp_q.pop_front());
	end
	always @(posedge mclk_in) if (cycles == 20000) begin
		fail_count++;
		report_and_stop();
	end
	task automatic tick(input int t);
		repeat (t) @(posedge mclk_in);
		#1;
	endtask
	// Channels are held disabled while their settings change, then enabled again.
	task automatic setup(input int ch, input int bl, input int md, input int cnt, input int r,
			input int ts);
		ch_enable_in[ch] = 1'b0;
		tick(1);
		ch_burst_len_in[ch*2 +: 2] = 2'(bl);
		ch_src_mode_in[ch*4 +: 4] = 4'(md);
		ch_blk_cnt_in[ch*16 +: 16] = 16'(cnt);
		ch_rep_cnt_in[ch*8 +: 8] = 8'(r);
		ch_trig_sel_in[ch*2 +: 2] = 2'(ts);
		ch_src_addr_in[ch*24 +: 24] = 24'(xs());
		ch_dst_addr_in[ch*24 +: 24] = 24'(xs());
		ch_enable_in[ch] = 1'b1;
		tick(1);
	endtask
	task automatic fire(input int ch);
		ch_sw_req_in[ch] = (ch_trig_sel_in[ch*2 +: 2] == 2'h0);
		ch_per_trig_in[ch] = (ch_trig_sel_in[ch*2 +: 2] == 2'h1);
		ch_evt_trig_in[ch] = (ch_trig_sel_in[ch*2 +: 2] == 2'h2);
		tick(1);
		{ch_sw_req_in[ch], ch_per_trig_in[ch], ch_evt_trig_in[ch]} = 3'h0;
	endtask
	task automatic plan(input int ch, input int cnt);
		int s, d;
		s = ch_src_addr_in[ch*24 +: 24];
		d = ch_dst_addr_in[ch*24 +: 24];
		for (int i = 0; i < cnt; i++) begin
			exp_q.push_back({d[23:0], s[7:0] ^ 8'h5a});
			s += step(ch_src_mode_in[ch*4 +: 2]);
			d += step(ch_src_mode_in[ch*4+2 +: 2]);
		end
	endtask
	task automatic settle(input int ch, input int dn, input int bytes);
		tick(3);
		for (int i = 0; i < 3000 && (ch_busy_out !== 4'h0 || ch_pend_out !== 4'h0); i++) tick(1);
		tick(4);
		check("bytes left", exp_q.size(), 0);
		check("complete count", ndone[ch], dn);
		check("checksum bytes", ncrc, bytes);
		ndone = '{default: 0};
		ncrc = 0;
	endtask
	initial begin
		tick(10);
		rst_in = 1'b0;
		tick(3);
		check("idle outputs", {ch_busy_out, ch_pend_out, ch_done_out, mem_rd_out, mem_wr_out}, 0);
		ctl_enable_in = 1'b1;
		stall = 1'b1;
		for (c = 0; c < 4; c++) begin
			n = xs() % 20 + 1;
			setup(c, c, ((c + 1) % 3) * 4 + c % 3, n, 0, c % 3);
			fire(c);
			plan(c, n);
			settle(c, 1, n);
		end
		setup(1, 0, 5, 3, 0, 1);
		trig_present_in = 4'hd;
		fire(1);
		tick(20);
		check("absent source", ch_busy_out[1], 1'b0);
		trig_present_in = 4'hf;
		fire(1);
		plan(1, 3);
		settle(1, 1, 3);
		setup(0, 0, 5, 2, 3, 0);
		ch_repeat_in[0] = 1'b1;
		fire(0);
		plan(0, 6);
		settle(0, 1, 6);
		ch_repeat_in[0] = 1'b0;
		for (k = 1; k < 4; k++) begin
			channel_priority_select_in = 2'(k);
			setup(0, 1, 5, 4, 0, 0);
			setup(1, 1, 6, 4, 0, 0);
			ch_sw_req_in = 4'h3;
			tick(1);
			ch_sw_req_in = 4'h0;
			plan(0, 4);
			plan(1, 4);
			settle(1, 1, 8);
		end
		setup(2, 1, 5, 8, 0, 0);
		ch_single_in[2] = 1'b1;
		hold = 1'b1;
		n = nrd;
		fire(2);
		tick(2);
		fire(2);
		tick(1);
		check("request held", ch_pend_out[2], 1'b1);
		fire(2);
		tick(20);
		check("reads under processor", nrd - n, 0);
		hold = 1'b0;
		plan(2, 4);
		tick(80);
		check("single bursts", exp_q.size(), 0);
		check("pending cleared", ch_pend_out[2], 1'b0);
		hold = 1'b1;
		fire(2);
		n = nerr;
		ch_enable_in[2] = 1'b0;
		tick(5);
		check("abort error", nerr - n, 1);
		hold = 1'b0;
		ch_single_in[2] = 1'b0;
		setup(1, 0, 5, 1, 0, 2);
		ch_repeat_in[1] = 1'b1;
		fire(1);
		plan(1, 40);
		for (k = 0; k < 500 && ndone[1] < 3; k++) tick(1);
		hold = 1'b1;
		tick(3);
		ch_enable_in[1] = 1'b0;
		hold = 1'b0;
		tick(10);
		check("endless repeat", ndone[1] >= 3, 1'b1);
		exp_q.delete();
		ch_repeat_in[1] = 1'b0;
		channel_priority_select_in = 2'h0;
		setup(3, 3, 5, 16, 0, 0);
		fire(3);
		plan(3, 16);
		n = nerr;
		tick(6);
		mem_err_in = 1'b1;
		tick(1);
		mem_err_in = 1'b0;
		tick(30);
		check("error ends transfer", {ch_busy_out[3], 7'(nerr - n)}, 8'h01);
		exp_q.delete();
		report_and_stop();
	end
endmodule // fcdma_top_test
`default_nettype wire
